//--- tmr_xfer_ctrl.v
`timescale 1ns/1ps
`include "tmr_defines.vh"
module tmr_xfer_ctrl (
    input wire clk,
    input wire sys_rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`TMR_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // command path, same clock
    input wire dataLineCmdInhibit,
    input wire cmdDone,
    input wire respShort,
    input wire [31:0] respWord,
    // settings toward the data path
    output wire xferMulti,
    output wire xferRead,
    output wire respCheckEn,
    output wire respFmtSel,
    output wire cmdIntSuppress,
    // interrupt
    output wire irq
);
    // ==========================================================
    // declarations
    reg intSuppress_r;
    reg intSuppress_nxt;
    reg chkEn_r;
    reg chkEn_nxt;
    reg fmtIo_r;
    reg fmtIo_nxt;
    reg multi_r;
    reg multi_nxt;
    reg dir_r;
    reg dir_nxt;
    reg [`TMR_XFER_W-1:0] xferView;
    reg [`TMR_IRQ_W-1:0] mask_r;
    reg [`TMR_IRQ_W-1:0] mask_nxt;
    reg [31:0] respLast_r;
    reg [31:0] errDetail_r;
    reg [31:0] prdata_r;
    reg [31:0] rdMux;
    reg addrHit;
    reg irq_r;
    wire [`TMR_IRQ_W-1:0] stat;
    wire [`TMR_IRQ_W-1:0] statSet;
    wire [`TMR_IRQ_W-1:0] statClr;
    wire [`TMR_IRQ_W-1:0] pending;
    wire [`TMR_XFER_W-1:0] xferRst;
    wire [`TMR_XFER_W-1:0] laneMask;
    wire [`TMR_XFER_W-1:0] xferWrMask;
    wire setupPhase;
    wire accessPhase;
    wire wrEn;
    wire rdLoad;
    wire hitXfer;
    wire hitStat;
    wire hitMask;
    wire wrXfer;
    wire xferWrOk;
    wire wrStat;
    wire wrMask;
    wire statWrOk;
    wire maskWrOk;
    wire cmdEvent;
    wire rerrEvent;
    wire chkErr;
    wire [31:0] chkBits;

    // ==========================================================
    // APB handshake
    // zero wait states: the access phase always completes at once
    assign pready = 1'b1;
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign pslverr = accessPhase & ~addrHit;
    assign wrEn = accessPhase & pwrite & addrHit;
    assign rdLoad = setupPhase & ~pwrite;
    assign prdata = prdata_r;

    // ==========================================================
    // register hits for the writable registers
    assign hitXfer = (paddr == `TMR_OFS_XFER);
    assign hitStat = (paddr == `TMR_OFS_ISTAT);
    assign hitMask = (paddr == `TMR_OFS_IMASK);

    // ==========================================================
    // write strobes
    assign wrXfer = wrEn & hitXfer;
    // the lock is sampled at the access edge, the edge that would take the write
    assign xferWrOk = wrXfer & ~dataLineCmdInhibit;
    assign wrStat = wrEn & hitStat;
    assign wrMask = wrEn & hitMask;

    // ==========================================================
    // address decode and read mux
    always @* begin
        rdMux = 32'h0000_0000;
        addrHit = 1'b1;
        case (paddr)
            `TMR_OFS_XFER: begin
                rdMux[`TMR_XFER_W-1:0] = xferView;
            end
            `TMR_OFS_RESP: begin
                rdMux = respLast_r;
            end
            `TMR_OFS_PSTATE: begin
                rdMux[`TMR_PS_DINH] = dataLineCmdInhibit;
            end
            `TMR_OFS_ISTAT: begin
                rdMux[`TMR_IRQ_W-1:0] = stat;
            end
            `TMR_OFS_IMASK: begin
                rdMux[`TMR_IRQ_W-1:0] = mask_r;
            end
            `TMR_OFS_EDET: begin
                rdMux = errDetail_r;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // read data is sampled in the setup cycle so it comes from a flop
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (rdLoad) begin
            prdata_r <= rdMux;
        end
    end

    // ==========================================================
    // transfer control register
    // only the implemented fields are writable; the rest stay zero
    assign xferWrMask = `TMR_XFER_WMASK;
    assign xferRst = `TMR_XFER_RST;
    assign laneMask = {{`TMR_LANE_W{pstrb[`TMR_LANE_HI]}}, {`TMR_LANE_W{pstrb[`TMR_LANE_LO]}}} & xferWrMask;

    // one flop per field, so a lane strobe touches only its own bits;
    // a locked write is dropped silently and still answers okay
    // suppress: the command-complete event is blocked at its source
    always @* begin
        intSuppress_nxt = intSuppress_r;
        if (xferWrOk & laneMask[`TMR_BIT_INT_DIS]) begin
            intSuppress_nxt = pwdata[`TMR_BIT_INT_DIS];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            intSuppress_r <= xferRst[`TMR_BIT_INT_DIS];
        end else begin
            intSuppress_r <= intSuppress_nxt;
        end
    end

    // check enable: only looked at when a response arrives
    always @* begin
        chkEn_nxt = chkEn_r;
        if (xferWrOk & laneMask[`TMR_BIT_CHK_EN]) begin
            chkEn_nxt = pwdata[`TMR_BIT_CHK_EN];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            chkEn_r <= xferRst[`TMR_BIT_CHK_EN];
        end else begin
            chkEn_r <= chkEn_nxt;
        end
    end

    // format: 0 memory status, 1 i/o status
    always @* begin
        fmtIo_nxt = fmtIo_r;
        if (xferWrOk & laneMask[`TMR_BIT_FMT]) begin
            fmtIo_nxt = pwdata[`TMR_BIT_FMT];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            fmtIo_r <= xferRst[`TMR_BIT_FMT];
        end else begin
            fmtIo_r <= fmtIo_nxt;
        end
    end

    // multiplicity: 1 multiple-block, 0 single-block
    always @* begin
        multi_nxt = multi_r;
        if (xferWrOk & laneMask[`TMR_BIT_MULTI]) begin
            multi_nxt = pwdata[`TMR_BIT_MULTI];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            multi_r <= xferRst[`TMR_BIT_MULTI];
        end else begin
            multi_r <= multi_nxt;
        end
    end

    // direction: 1 card to host, 0 host to card
    always @* begin
        dir_nxt = dir_r;
        if (xferWrOk & laneMask[`TMR_BIT_DIR]) begin
            dir_nxt = pwdata[`TMR_BIT_DIR];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            dir_r <= xferRst[`TMR_BIT_DIR];
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // read view: reserved and unimplemented bits stay zero
    always @* begin
        xferView = {`TMR_XFER_W{1'b0}};
        xferView[`TMR_BIT_INT_DIS] = intSuppress_r;
        xferView[`TMR_BIT_CHK_EN] = chkEn_r;
        xferView[`TMR_BIT_FMT] = fmtIo_r;
        xferView[`TMR_BIT_MULTI] = multi_r;
        xferView[`TMR_BIT_DIR] = dir_r;
    end

    // fields straight to the command and data paths
    assign xferMulti = multi_r;
    assign xferRead = dir_r;
    assign respCheckEn = chkEn_r;
    assign respFmtSel = fmtIo_r;
    assign cmdIntSuppress = intSuppress_r;

    // ==========================================================
    // response capture
    // the last response stays readable for software that checks it itself
    always @(posedge clk) begin
        if (sys_rst) begin
            respLast_r <= 32'h0000_0000;
        end else if (cmdDone) begin
            respLast_r <= respWord;
        end
    end

    // ==========================================================
    // automatic response check
    tmr_resp_check u_check (
        .clk(clk),
        .sys_rst(sys_rst),
        .respValid(cmdDone),
        .respShort(respShort),
        .checkEn(respCheckEn),
        .fmtIo(respFmtSel),
        .respWord(respWord),
        .errPulse(chkErr),
        .errBits(chkBits)
    );

    // detail holds the offending bits of the last failing check
    always @(posedge clk) begin
        if (sys_rst) begin
            errDetail_r <= 32'h0000_0000;
        end else if (chkErr) begin
            errDetail_r <= chkBits;
        end
    end

    // ==========================================================
    // interrupt status and mask
    // suppression stops the event itself, so the mask cannot revive it
    assign cmdEvent = cmdDone & ~intSuppress_r;
    assign rerrEvent = chkErr;
    assign statSet[`TMR_IRQ_CMD] = cmdEvent;
    assign statSet[`TMR_IRQ_RERR] = rerrEvent;
    assign statWrOk = wrStat & pstrb[`TMR_LANE_LO];
    assign statClr = statWrOk ? pwdata[`TMR_IRQ_W-1:0] : `TMR_IRQ_RST;

    tmr_sticky #(
        .W(`TMR_IRQ_W)
    ) u_stat (
        .clk(clk),
        .sys_rst(sys_rst),
        .setBits(statSet),
        .clrBits(statClr),
        .stat(stat)
    );

    assign maskWrOk = wrMask & pstrb[`TMR_LANE_LO];

    always @* begin
        mask_nxt = mask_r;
        if (maskWrOk) begin
            mask_nxt = pwdata[`TMR_IRQ_W-1:0];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            mask_r <= `TMR_IRQ_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // only unmasked sticky bits count toward the pin
    assign pending = stat & mask_r;

    // registered so the pin never glitches while status and mask move
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |pending;
        end
    end

    assign irq = irq_r;
endmodule // tmr_xfer_ctrl

//--- tmr_defines.vh
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
// ==========================================================
// register map (byte addresses, APB)
`define TMR_ADDR_W 8
`define TMR_OFS_XFER 8'h0C
`define TMR_OFS_RESP 8'h10
`define TMR_OFS_PSTATE 8'h24
`define TMR_OFS_ISTAT 8'h30
`define TMR_OFS_IMASK 8'h34
`define TMR_OFS_EDET 8'h38
// ==========================================================
// transfer control fields
`define TMR_XFER_W 16
`define TMR_BIT_INT_DIS 8
`define TMR_BIT_CHK_EN 7
`define TMR_BIT_FMT 6
`define TMR_BIT_MULTI 5
`define TMR_BIT_DIR 4
`define TMR_XFER_WMASK 16'h01F0
`define TMR_XFER_RST 16'h0000
`define TMR_LANE_W 8
`define TMR_LANE_LO 0
`define TMR_LANE_HI 1
// ==========================================================
// response error masks
`define TMR_R1_ERR_MASK 32'hE6B8_0000
`define TMR_R5_ERR_MASK 32'h0000_008B
// ==========================================================
// interrupt status / mask layout; present-state inhibit bit
`define TMR_IRQ_W 2
`define TMR_IRQ_CMD 0
`define TMR_IRQ_RERR 1
`define TMR_IRQ_RST 2'h0
`define TMR_PS_DINH 1
`endif

//--- tmr_sticky.v
`timescale 1ns/1ps
// ==========================================================
// sticky status bits, write-one-to-clear; set beats clear
module tmr_sticky #(
    parameter W = 2
) (
    input wire clk,
    input wire sys_rst,
    input wire [W-1:0] setBits,
    input wire [W-1:0] clrBits,
    output wire [W-1:0] stat
);
    reg [W-1:0] stat_r;
    wire [W-1:0] stat_nxt;

    assign stat_nxt = (stat_r & ~clrBits) | setBits;
    assign stat = stat_r;

    always @(posedge clk) begin
        if (sys_rst) begin
            stat_r <= {W{1'b0}};
        end else begin
            stat_r <= stat_nxt;
        end
    end
endmodule // tmr_sticky

//--- tmr_resp_check.v
`timescale 1ns/1ps
`include "tmr_defines.vh"
// ==========================================================
// response error check; result one cycle after the response
module tmr_resp_check (
    input wire clk,
    input wire sys_rst,
    input wire respValid,
    input wire respShort,
    input wire checkEn,
    input wire fmtIo,
    input wire [31:0] respWord,
    output wire errPulse,
    output wire [31:0] errBits
);
    reg errPulse_r;
    reg [31:0] errBits_r;
    wire [31:0] fmtMask;
    wire [31:0] hitBits;
    wire doCheck;

    // format select: 0 memory status, 1 i/o status
    assign fmtMask = fmtIo ? `TMR_R5_ERR_MASK : `TMR_R1_ERR_MASK;
    // only short status formats are ever evaluated
    assign doCheck = respValid & respShort & checkEn;
    assign hitBits = respWord & fmtMask;
    assign errPulse = errPulse_r;
    assign errBits = errBits_r;

    always @(posedge clk) begin
        if (sys_rst) begin
            errPulse_r <= 1'b0;
            errBits_r <= 32'h0000_0000;
        end else begin
            errPulse_r <= doCheck & (|hitBits);
            if (doCheck) begin
                errBits_r <= hitBits;
            end
        end
    end
endmodule // tmr_resp_check

//--- tmr_card_model.sv
`timescale 1ns/1ps
// ==========================================================
// card side: answers one command after a chosen delay
module tmr_card_model (
    input wire clk,
    output logic cmdDone,
    output logic respShort,
    output logic [31:0] respWord
);
    initial cmdDone = 1'b0;
    initial respShort = 1'b0;
    initial respWord = 32'h0;
    // outside the strobe the word is inverted so nothing leans on a stale value
    task automatic respond(input integer lag, input logic s, input logic [31:0] w);
        repeat (lag) @(posedge clk);
        cmdDone <= 1'b1;
        respShort <= s;
        respWord <= w;
        @(posedge clk);
        cmdDone <= 1'b0;
        respShort <= ~s;
        respWord <= ~w;
    endtask
endmodule // tmr_card_model

//--- tmr_xfer_ctrl_checker.sv
`timescale 1ns/1ps
`include "tmr_defines.vh"
// ==========================================================
// port checks; the irq ones rely on commands being spaced apart
module tmr_xfer_ctrl_checker (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`TMR_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire dataLineCmdInhibit,
    input wire cmdDone,
    input wire respShort,
    input wire [31:0] respWord,
    input wire xferMulti,
    input wire xferRead,
    input wire respCheckEn,
    input wire respFmtSel,
    input wire cmdIntSuppress,
    input wire irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire xferAcc = psel && penable && paddr == `TMR_OFS_XFER;
    wire xferWr = xferAcc && pwrite && !dataLineCmdInhibit;
    wire quiet = cmdDone && cmdIntSuppress && !irq;
    multi_sel_a: assert property (xferWr |=> xferMulti == $past(pwdata[5])) else $error("multi bit");
    dir_sel_a: assert property (xferWr |=> xferRead == $past(pwdata[4])) else $error("direction bit");
    chk_sel_a:
        assert property (xferWr |=> respCheckEn == $past(pwdata[`TMR_BIT_CHK_EN])) else $error("check enable bit");
    fmt_sel_a:
        assert property (xferWr |=> respFmtSel == $past(pwdata[`TMR_BIT_FMT])) else $error("format bit");
    supp_sel_a:
        assert property (xferWr |=> cmdIntSuppress == $past(pwdata[`TMR_BIT_INT_DIS])) else $error("suppress bit");
    wr_lock_a:
        assert property (xferAcc && pwrite && dataLineCmdInhibit |=> $stable({xferMulti, xferRead, respCheckEn,
            respFmtSel, cmdIntSuppress})) else $error("locked write landed");
    rsvd_zero_a: assert property (xferAcc && !pwrite |-> prdata[15:9] == 7'h0) else $error("reserved bits");
    supp_irq_a: assert property (quiet |=> ##1 !irq) else $error("suppressed irq");
    short_only_a: assert property (quiet && !respShort |=> !irq [*3]) else $error("long format");
    chk_off_a: assert property (quiet && !respCheckEn |=> !irq [*3]) else $error("check not off");
    r1_clean_a:
        assert property (quiet && !respFmtSel && (respWord & `TMR_R1_ERR_MASK) == 32'h0 |=> !irq [*3])
            else $error("false memory error");
    r5_clean_a:
        assert property (quiet && respFmtSel && (respWord & `TMR_R5_ERR_MASK) == 32'h0 |=> !irq [*3])
            else $error("false io error");
    cover property (xferAcc && pwrite && dataLineCmdInhibit);
    cover property (quiet && respCheckEn && respFmtSel);
    cover property (quiet && respCheckEn && !respFmtSel);
endmodule // tmr_xfer_ctrl_checker
bind tmr_xfer_ctrl tmr_xfer_ctrl_checker chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .dataLineCmdInhibit, .cmdDone, .respShort, .respWord, .xferMulti, .xferRead, .respCheckEn,
    .respFmtSel, .cmdIntSuppress, .irq);

//--- transfer_mode_response_check_test.sv
`timescale 1ns/1ps
`include "tmr_defines.vh"
// ==========================================================
// register and response checks through the APB port
module transfer_mode_response_check_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic inhibit = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] d;
    logic [32:0] e;
    logic [32:0] expQ[$];
    logic [1:0] imask = 2'h0;
    wire [31:0] prdata;
    wire [31:0] respWord;
    wire pready, pslverr, cmdDone, respShort, irq;
    integer seed = 17140;
    integer fail_count = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer i;
    tmr_xfer_ctrl dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .dataLineCmdInhibit(inhibit), .cmdDone, .respShort, .respWord, .xferMulti(),
        .xferRead(), .respCheckEn(), .respFmtSel(), .cmdIntSuppress(), .irq);
    tmr_card_model card (.clk, .cmdDone, .respShort, .respWord);
    initial forever #10 clk = ~clk;
    task automatic bad(input string m);
        fail_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic results;
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // every transfer notes {pslverr, prdata}; data is ignored on writes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [32:0] x);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        expQ.push_back(x);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] x, input logic s, input logic [31:0] w, input logic [1:0] st,
        input logic [31:0] m);
        apb(1'b1, `TMR_OFS_XFER, x, 33'h0);
        card.respond($unsigned($random(seed)) % 4, s, w);
        repeat (6) @(posedge clk);
        check_count++;
        if (irq !== |(st & imask)) bad("irq level");
        apb(1'b0, `TMR_OFS_RESP, 32'h0, {1'b0, w});
        apb(1'b0, `TMR_OFS_ISTAT, 32'h0, {31'h0, st});
        if (st[1]) apb(1'b0, `TMR_OFS_EDET, 32'h0, {1'b0, w & m});
        apb(1'b1, `TMR_OFS_ISTAT, 32'h3, 33'h0);
    endtask
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = expQ.pop_front();
            check_count++;
            if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) bad("apb answer");
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `TMR_OFS_XFER, 32'h0, 33'h0);
        apb(1'b1, `TMR_OFS_IMASK, 32'h3, 33'h0);
        imask = 2'h3;
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            apb(1'b1, `TMR_OFS_XFER, d, 33'h0);
            apb(1'b0, `TMR_OFS_XFER, 32'h0, {1'b0, d & 32'h1F0});
        end
        inhibit <= 1'b1;
        apb(1'b0, `TMR_OFS_PSTATE, 32'h0, 33'h2);
        apb(1'b1, `TMR_OFS_XFER, ~d, 33'h0);
        apb(1'b0, `TMR_OFS_XFER, 32'h0, {1'b0, d & 32'h1F0});
        inhibit <= 1'b0;
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
        cmd(32'h000, 1'b1, 32'hFFFF_FFFF, 2'h1, 32'h0);
        cmd(32'h100, 1'b1, 32'hFFFF_FFFF, 2'h0, 32'h0);
        for (i = 0; i < 32; i++) begin
            d = $random(seed);
            if (((`TMR_R1_ERR_MASK >> i) & 32'h1) != 32'h0)
                cmd(32'h180, 1'b1, (32'h1 << i) | (d & ~`TMR_R1_ERR_MASK), 2'h2, `TMR_R1_ERR_MASK);
            if (((`TMR_R5_ERR_MASK >> i) & 32'h1) != 32'h0)
                cmd(32'h1C0, 1'b1, (32'h1 << i) | (d & ~`TMR_R5_ERR_MASK), 2'h2, `TMR_R5_ERR_MASK);
        end
        cmd(32'h180, 1'b1, d & ~`TMR_R1_ERR_MASK, 2'h0, 32'h0);
        cmd(32'h1C0, 1'b1, `TMR_R1_ERR_MASK, 2'h0, 32'h0);
        cmd(32'h180, 1'b0, 32'hFFFF_FFFF, 2'h0, 32'h0);
        apb(1'b1, `TMR_OFS_IMASK, 32'h1, 33'h0);
        imask = 2'h1;
        cmd(32'h180, 1'b1, `TMR_R1_ERR_MASK, 2'h2, `TMR_R1_ERR_MASK);
        results();
    end
endmodule // transfer_mode_response_check_test
